//--- logic/dopc_pkg.sv
package dopc_pkg;
    localparam logic [7:0] DOPC_OFF_LUMA   = 8'h0c;
    localparam logic [7:0] DOPC_OFF_CHROMA = 8'h0d;
    localparam logic [7:0] DOPC_OFF_SKIP   = 8'h0e;
    localparam logic [7:0] DOPC_OFF_POWER  = 8'h0f;
    localparam logic [7:0] DOPC_OFF_STATUS = 8'h20;
    localparam logic [7:0] DOPC_RST_LUMA   = 8'h10;
    localparam logic [7:0] DOPC_RST_CHROMA = 8'h88;
    localparam logic [7:0] DOPC_RST_SKIP   = 8'h00;
    localparam logic [7:0] DOPC_RST_POWER  = 8'h00;
    localparam int DOPC_BIT_FORCE     = 0;
    localparam int DOPC_BIT_AUTO      = 1;
    localparam int DOPC_BIT_SKIP_EN   = 0;
    localparam int DOPC_BIT_PRIO      = 2;
    localparam int DOPC_BIT_REF_SAVE  = 3;
    localparam int DOPC_BIT_CG_SAVE   = 4;
    localparam int DOPC_BIT_SHUTDOWN  = 5;
    localparam int DOPC_BIT_REACQ     = 6;
    localparam int DOPC_BIT_CORE_RST  = 7;
    localparam int DOPC_CORE_RST_CYC  = 4;

    typedef enum logic [1:0] {
        DOPC_SAVE_FULL, DOPC_SAVE_COMPOSITE, DOPC_SAVE_DIGITAL, DOPC_SAVE_ALL
    } dopc_save_t;

    typedef struct packed {
        logic [7:0] y;
        logic [7:0] cr;
        logic [7:0] cb;
    } dopc_pix_t;

    typedef struct packed {
        logic       en;
        logic [1:0] mode;
        logic [3:0] rate;
    } dopc_skip_cfg_t;
endpackage : dopc_pkg

//--- logic/dopc_field_skip.sv
module dopc_field_skip
    import dopc_pkg::*;
(
    input  wire logic           i_clk,
    input  wire logic           i_rst_n,
    input  wire dopc_skip_cfg_t i_cfg,
    input  wire logic           i_field_start,
    input  wire logic           i_field_odd,
    output logic                o_pass
);
    dopc_skip_cfg_t cfg_q;
    logic [3:0]     cnt_q, cnt_d;
    logic           pass_q, pass_d;
    logic           in_frame_q, in_frame_d;
    logic           cfg_change;
    logic           frame_mode;
    logic           first_fld;
    logic           cand;

    assign cfg_change = (i_cfg != cfg_q);
    assign frame_mode = ~i_cfg.mode[1];
    // frame starts with odd when mode 01, even when 00
    assign first_fld  = (i_field_odd == i_cfg.mode[0]);
    // field modes: only the selected parity takes part in skipping
    assign cand       = frame_mode ? (first_fld | in_frame_q)
                                   : (i_field_odd == i_cfg.mode[0]);

    always_comb begin
        cnt_d      = cnt_q;
        pass_d     = pass_q;
        in_frame_d = in_frame_q;
        if (cfg_change) begin
            cnt_d      = 4'h0;
            pass_d     = 1'b1;
            in_frame_d = 1'b0;
        end else if (!i_cfg.en) begin
            pass_d = 1'b1;
        end else if (i_field_start) begin
            if (frame_mode && !first_fld && in_frame_q) begin
                in_frame_d = 1'b0; // second field follows its frame decision
            end else if (frame_mode && !first_fld) begin
                pass_d = 1'b0;
            end else if (cand) begin
                in_frame_d = frame_mode;
                if (cnt_q == i_cfg.rate) begin
                    pass_d = 1'b1;
                    cnt_d  = 4'h0;
                end else begin
                    pass_d = 1'b0;
                    cnt_d  = cnt_q + 4'h1;
                end
            end else begin
                pass_d = 1'b1; // other parity always output
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_q      <= '0;
            cnt_q      <= 4'h0;
            pass_q     <= 1'b1;
            in_frame_q <= 1'b0;
        end else begin
            cfg_q      <= i_cfg;
            cnt_q      <= cnt_d;
            pass_q     <= pass_d;
            in_frame_q <= in_frame_d;
        end
    end

    assign o_pass = pass_q;
endmodule : dopc_field_skip

//--- logic/dopc_top.sv
module dopc_top
    import dopc_pkg::*;
#(
    parameter int CORE_RST_CYC = DOPC_CORE_RST_CYC
) (
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    input  wire logic       i_lock,
    input  wire logic       i_pd_pin,
    input  wire logic       i_reacq_pin,
    input  wire dopc_pix_t  i_pix,
    input  wire logic       i_pix_valid,
    input  wire logic       i_field_start,
    input  wire logic       i_field_odd,
    output dopc_pix_t       o_pix,
    output logic            o_pix_valid,
    output logic      [1:0] o_save_mode_select,
    output logic            o_reference_save,
    output logic            o_clockgen_save,
    output logic            o_core_shutdown,
    output logic            o_pad_disable,
    output logic            o_reacquire_cmd,
    output logic            o_core_reset
);
    logic       rst_s1_q, rst_n_q;
    logic       lock_s1_q, lock_q;
    logic       pd_s1_q, pd_q;
    logic       rq_s1_q, rq_q;
    logic [7:0] luma_q;
    logic [7:0] chroma_q;
    logic [7:0] skip_q;
    logic [5:0] power_q;
    logic       reacq_q;
    logic       core_rst_q;
    logic [7:0] rst_cnt_q;
    logic [7:0] rdata_q;
    dopc_pix_t  pix_q;
    logic       pix_valid_q;

    logic           wr_luma, wr_chroma, wr_skip, wr_power;
    logic           force_default_out, auto_default_on_unlock, use_fill;
    logic [5:0]     luma_fill_value;
    logic [7:0]     chroma_fill_value;
    dopc_pix_t      fill_pix;
    dopc_skip_cfg_t skip_cfg;
    logic           field_pass;
    logic           shutdown;
    logic [7:0]     rd_mux;
    logic [7:0]     status;

    // reset release and pin synchronisers
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            lock_s1_q <= 1'b0;
            lock_q    <= 1'b0;
            pd_s1_q   <= 1'b0;
            pd_q      <= 1'b0;
            rq_s1_q   <= 1'b0;
            rq_q      <= 1'b0;
        end else begin
            lock_s1_q <= i_lock;
            lock_q    <= lock_s1_q;
            pd_s1_q   <= i_pd_pin;
            pd_q      <= pd_s1_q;
            rq_s1_q   <= i_reacq_pin;
            rq_q      <= rq_s1_q;
        end
    end

    // address decode
    assign wr_luma   = i_wr && (i_addr == DOPC_OFF_LUMA);
    assign wr_chroma = i_wr && (i_addr == DOPC_OFF_CHROMA);
    assign wr_skip   = i_wr && (i_addr == DOPC_OFF_SKIP);
    assign wr_power  = i_wr && (i_addr == DOPC_OFF_POWER);

    // register file
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            luma_q   <= DOPC_RST_LUMA;
            chroma_q <= DOPC_RST_CHROMA;
            skip_q   <= DOPC_RST_SKIP;
            power_q  <= DOPC_RST_POWER[5:0];
        end else begin
            if (wr_luma) begin
                luma_q <= i_wdata;
            end
            if (wr_chroma) begin
                chroma_q <= i_wdata;
            end
            if (wr_skip) begin
                skip_q <= {1'b0, i_wdata[6:0]};
            end
            if (wr_power) begin
                power_q <= i_wdata[5:0];
            end
        end
    end

    // self-clearing commands
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            reacq_q    <= 1'b0;
            core_rst_q <= 1'b0;
            rst_cnt_q  <= 8'h00;
        end else begin
            reacq_q <= wr_power && i_wdata[DOPC_BIT_REACQ];
            if (wr_power && i_wdata[DOPC_BIT_CORE_RST]) begin
                core_rst_q <= 1'b1;
                rst_cnt_q  <= 8'(CORE_RST_CYC - 1);
            end else if (rst_cnt_q != 8'h00) begin
                rst_cnt_q <= rst_cnt_q - 8'h01;
            end else begin
                core_rst_q <= 1'b0;
            end
        end
    end

    // fill value selection
    assign force_default_out      = luma_q[DOPC_BIT_FORCE];
    assign auto_default_on_unlock = luma_q[DOPC_BIT_AUTO];
    assign luma_fill_value        = luma_q[7:2];
    assign chroma_fill_value      = chroma_q;
    assign use_fill = force_default_out | (auto_default_on_unlock & ~lock_q);
    assign fill_pix = {luma_fill_value, 2'b00,
                       chroma_fill_value[7:4], 4'h0,
                       chroma_fill_value[3:0], 4'h0};

    assign skip_cfg = {skip_q[DOPC_BIT_SKIP_EN], skip_q[2:1], skip_q[6:3]};

    dopc_field_skip u_skip (
        .i_clk         (i_clk),
        .i_rst_n       (rst_n_q),
        .i_cfg         (skip_cfg),
        .i_field_start (i_field_start),
        .i_field_odd   (i_field_odd),
        .o_pass        (field_pass)
    );

    // power control
    assign shutdown = power_q[DOPC_BIT_PRIO] ? power_q[DOPC_BIT_SHUTDOWN] : pd_q;

    // pixel output stage
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pix_q       <= '0;
            pix_valid_q <= 1'b0;
        end else begin
            pix_q       <= use_fill ? fill_pix : i_pix;
            pix_valid_q <= i_pix_valid && field_pass && !shutdown;
        end
    end

    // readback
    assign status = {5'h00, shutdown, lock_q, field_pass};
    assign rd_mux = (i_addr == DOPC_OFF_LUMA)   ? luma_q :
                    (i_addr == DOPC_OFF_CHROMA) ? chroma_q :
                    (i_addr == DOPC_OFF_SKIP)   ? skip_q :
                    (i_addr == DOPC_OFF_POWER)  ? {core_rst_q, reacq_q, power_q} :
                    (i_addr == DOPC_OFF_STATUS) ? status : 8'h00;

    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= i_rd ? rd_mux : 8'h00;
        end
    end

    assign o_rdata            = rdata_q;
    assign o_pix              = pix_q;
    assign o_pix_valid        = pix_valid_q;
    assign o_save_mode_select = power_q[1:0];
    assign o_reference_save   = power_q[DOPC_BIT_REF_SAVE];
    assign o_clockgen_save    = power_q[DOPC_BIT_CG_SAVE];
    assign o_core_shutdown    = shutdown;
    assign o_pad_disable      = shutdown;
    assign o_reacquire_cmd    = reacq_q | rq_q;
    assign o_core_reset       = core_rst_q;
endmodule : dopc_top

//--- verification/dopc_monitor.sv
module dopc_monitor
    import dopc_pkg::*;
(
    input wire logic       i_clk,
    input wire logic       i_resetn,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic       o_pix_valid,
    input wire logic [1:0] o_save_mode_select,
    input wire logic       o_reference_save,
    input wire logic       o_clockgen_save,
    input wire logic       o_core_shutdown,
    input wire logic       o_pad_disable,
    input wire logic       o_reacquire_cmd,
    input wire logic       o_core_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    logic [7:0] wd_q;
    wire        pw = i_wr && (i_addr == DOPC_OFF_POWER);
    always_ff @(posedge i_clk) wd_q <= i_wdata;
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not idle");
    a_save_follow: assert property (pw |=> o_save_mode_select == wd_q[1:0])
        else $error("save mode wrong");
    a_save_bits: assert property (pw |=> {o_clockgen_save, o_reference_save} == wd_q[4:3])
        else $error("save bits wrong");
    a_prio_bit: assert property (pw && i_wdata[2] |=> o_core_shutdown == wd_q[5])
        else $error("bit priority wrong");
    a_pad_tie: assert property (o_pad_disable == o_core_shutdown)
        else $error("pads not with shutdown");
    a_reacq_pulse: assert property (pw && i_wdata[6] |=> o_reacquire_cmd)
        else $error("no reacquire pulse");
    a_core_rst: assert property (pw && i_wdata[7] |=> o_core_reset)
        else $error("no core reset");
    a_save_hold: assert property (!pw |=> $stable(o_save_mode_select))
        else $error("save mode moved");
    a_dark_shut: assert property (o_core_shutdown [*2] |-> !o_pix_valid)
        else $error("pixel during shutdown");
endmodule : dopc_monitor

bind dopc_top dopc_monitor dopc_monitor_inst (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_pix_valid(o_pix_valid), .o_save_mode_select(o_save_mode_select),
    .o_reference_save(o_reference_save), .o_clockgen_save(o_clockgen_save),
    .o_core_shutdown(o_core_shutdown), .o_pad_disable(o_pad_disable),
    .o_reacquire_cmd(o_reacquire_cmd), .o_core_reset(o_core_reset));

//--- verification/dopc_sink.sv
module dopc_sink (
    input  wire logic i_clk,
    input  wire logic i_valid,
    output int        o_count
);
    timeunit 1ns;
    timeprecision 1ps;
    int seen = 0;
    assign o_count = seen;
    // counts pixels accepted downstream
    always @(posedge i_clk) begin
        if (i_valid === 1'b1) seen <= seen + 1;
    end
endmodule : dopc_sink

//--- verification/tb.sv
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("BAD %0t got %h exp %h", $time, a, b); end end
module tb;
    import dopc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rstn = 0, wr = 0, rd = 0, lock = 1, pdp = 0, rqp = 0, pv = 0, fs = 0, fo = 0;
    logic [7:0] ad = 0, wd = 0;
    logic [31:0] r, s = 47884;
    logic odd, ev, sp, fr;
    dopc_pix_t px = '0, opx;
    wire [7:0] rdata;
    wire [1:0] save_mode_select;
    wire ov, rq, crst, shut, pad, rs, cs;
    int mismatches = 0, n_checks = 0, cyc = 0, cnt, cnt0, c, n, npass;
    int regs[4] = '{8'h10, 8'h88, 0, 0};
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin mismatches++; final_report(); end
    end
    dopc_top #(.CORE_RST_CYC(2)) dopc_top_inst (.i_clk(clk), .i_resetn(rstn), .i_addr(ad),
        .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_lock(lock), .i_pd_pin(pdp),
        .i_reacq_pin(rqp), .i_pix(px), .i_pix_valid(pv), .i_field_start(fs), .i_field_odd(fo),
        .o_pix(opx), .o_pix_valid(ov), .o_save_mode_select(save_mode_select), .o_reference_save(rs),
        .o_clockgen_save(cs), .o_core_shutdown(shut), .o_pad_disable(pad),
        .o_reacquire_cmd(rq), .o_core_reset(crst));
    dopc_sink dopc_sink_inst (.i_clk(clk), .i_valid(ov), .o_count(cnt));
    function automatic logic [31:0] xs();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk); ad <= a; wd <= d; wr <= 1;
        @(posedge clk); wr <= 0;
        if (a >= 8'h0c && a <= 8'h0f) regs[a-12] = d & (a == 14 ? 8'h7f : a == 15 ? 8'h3f : 8'hff);
    endtask : wreg
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk); ad <= a; rd <= 1;
        @(posedge clk); rd <= 0;
        #1 `CHK(rdata, e)
    endtask : rreg
    task automatic pix(input logic e);
        dopc_pix_t p, f;
        r = xs();
        p = r[23:0];
        f = {regs[0][7:2], 2'b0, regs[1][7:4], 4'h0, regs[1][3:0], 4'h0};
        @(posedge clk); px <= p; pv <= 1;
        @(posedge clk); pv <= 0;
        #1 `CHK(ov, e)
        if (e) `CHK(opx, (regs[0][0] || (regs[0][1] && !lock)) ? f : p)
    endtask : pix
    task automatic field(input logic o, input logic e);
        @(posedge clk); fs <= 1; fo <= o;
        @(posedge clk); fs <= 0;
        @(posedge clk);
        pix(e);
    endtask : field
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1;
        repeat (3) @(posedge clk);
        for (int a = 12; a < 16; a++) rreg(a, regs[a-12]);
        rreg(8'h30, 8'h00);
        rreg(DOPC_OFF_STATUS, 8'h03);
        $display("test reset done");
        r = xs();
        wreg(8'h0d, r[7:0]);
        rreg(8'h0d, regs[1]);
        for (int i = 0; i < 8; i++) begin
            r = xs();
            lock <= i[2];
            wreg(8'h0c, {r[7:2], i[1:0]});
            repeat (4) @(posedge clk);
            rreg(8'h0c, regs[0]);
            pix(1);
        end
        $display("test fill done");
        for (int i = 0; i < 4; i++) begin
            r = xs();
            wreg(8'h0f, {2'b0, r[5:3], 1'b1, i[1:0]});
            #1 `CHK({pad, shut, cs, rs, save_mode_select}, {r[5], r[5:3], i[1:0]})
            rreg(8'h0f, regs[3]);
        end
        wreg(8'h0f, 8'h20);
        #1 `CHK(shut, 1'b0)
        pdp <= 1;
        repeat (4) @(posedge clk);
        #1 `CHK({pad, shut}, 2'b11)
        pix(0);
        wreg(8'h0f, 8'h04);
        #1 `CHK(shut, 1'b0)
        pdp <= 0;
        wreg(8'h0f, 8'h40);
        #1 `CHK(rq, 1'b1)
        @(posedge clk);
        #1 `CHK(rq, 1'b0)
        rreg(8'h0f, regs[3]);
        rqp <= 1;
        repeat (4) @(posedge clk);
        #1 `CHK(rq, 1'b1)
        rqp <= 0;
        lock <= 1;
        wreg(8'h0c, 8'h40);
        $display("test power done");
        for (int m = 0; m < 5; m++) begin
            wreg(8'h0e, {1'b1, m[3:0], m[1:0], m < 4});
            rreg(8'h0e, regs[2]);
            c = 0;
            npass = 0;
            cnt0 = cnt;
            sp = (m == 1);
            for (int k = 0; k < 8; k++) begin
                odd = sp ^ k[0];
                ev = 1;
                if (m < 2 && odd != sp) ev = fr;
                else if (m < 4 && (m < 2 || odd == m[0])) begin
                    ev = (c == m);
                    c = ev ? 0 : c + 1;
                end
                fr = ev;
                npass += ev;
                field(odd, ev);
            end
            @(posedge clk);
            #1 `CHK(cnt - cnt0, npass)
        end
        $display("test skip done");
        wreg(8'h0f, 8'h80);
        #1 n = 0;
        while (crst === 1'b1 && n < 50) begin n++; @(posedge clk); #1; end
        `CHK(n, 2)
        rreg(8'h0f, regs[3]);
        $display("test core reset done");
        final_report();
    end
endmodule : tb
